// *** hsa_adjust.sv ***
`timescale 1ns/1ps
module hsa_adjust #(
    parameter int PIX_W = 8
) (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic [hsa_pkg::AVS_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_pix_valid,
    input wire logic [PIX_W-1:0] i_pix_r,
    input wire logic [PIX_W-1:0] i_pix_g,
    input wire logic [PIX_W-1:0] i_pix_b,
    output logic o_pix_valid,
    output logic [PIX_W-1:0] o_pix_r,
    output logic [PIX_W-1:0] o_pix_g,
    output logic [PIX_W-1:0] o_pix_b,
    output logic o_matrix_bypass,
    output logic o_adjust_active
);
    localparam int SUM_W = PIX_W + 4;

    generate
        if (PIX_W < 4 || PIX_W > 16)
        begin : g_bad_width
            $error("hsa_adjust: PIX_W must be 4 to 16");
        end
    endgenerate

    // Register file
    logic wait_r;
    logic wait_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [31:0] rd_word;
    logic en_r;
    logic en_nxt;
    logic raw_r;
    logic raw_nxt;
    logic bayer_r;
    logic bayer_nxt;
    hsa_pkg::hsa_light_t ls_r;
    hsa_pkg::hsa_light_t ls_nxt;
    hsa_pkg::hsa_colour_t sel_r;
    hsa_pkg::hsa_colour_t sel_nxt;
    logic [7:0] hue_r [hsa_pkg::NUM_COLOURS];
    logic [7:0] hue_nxt [hsa_pkg::NUM_COLOURS];
    logic [7:0] sat_r [hsa_pkg::NUM_COLOURS];
    logic [7:0] sat_nxt [hsa_pkg::NUM_COLOURS];
    logic act_r;
    logic act_nxt;
    logic byp_r;
    logic byp_nxt;
    logic req;
    logic wr_commit;
    logic act_c;

    assign req = i_avs_read | i_avs_write;
    assign wr_commit = i_avs_write & ~wait_r & i_avs_byteenable[0];
    // Bayer output needs processed-raw; other formats ignore it
    assign act_c = en_r & (~bayer_r | raw_r);

    always_comb
    begin
        rd_word = 32'h0000_0000;
        unique case (i_avs_address)
            hsa_pkg::OFS_CTRL:
            begin
                rd_word[hsa_pkg::CTRL_EN_BIT] = en_r;
                rd_word[hsa_pkg::CTRL_RAW_BIT] = raw_r;
                rd_word[hsa_pkg::CTRL_BAYER_BIT] = bayer_r;
                rd_word[hsa_pkg::CTRL_LS_LSB +: 3] = ls_r;
            end
            hsa_pkg::OFS_SEL: rd_word[2:0] = sel_r;
            hsa_pkg::OFS_HUE: rd_word[7:0] = hue_r[sel_r];
            hsa_pkg::OFS_SAT: rd_word[7:0] = sat_r[sel_r];
            hsa_pkg::OFS_STAT:
            begin
                rd_word[hsa_pkg::STAT_ACT_BIT] = act_r;
                rd_word[hsa_pkg::STAT_BYP_BIT] = byp_r;
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_comb
    begin
        logic load;
        hsa_pkg::hsa_light_t load_src;
        load = 1'b0;
        load_src = ls_r;
        wait_nxt = 1'b1;
        rdata_nxt = rdata_r;
        en_nxt = en_r;
        raw_nxt = raw_r;
        bayer_nxt = bayer_r;
        ls_nxt = ls_r;
        sel_nxt = sel_r;
        hue_nxt = hue_r;
        sat_nxt = sat_r;
        act_nxt = act_c;
        byp_nxt = bayer_r & ~raw_r;
        // One wait cycle, then the access completes
        if (req && wait_r)
        begin
            wait_nxt = 1'b0;
            rdata_nxt = i_avs_read ? rd_word : 32'h0000_0000;
        end
        if (wr_commit)
        begin
            unique case (i_avs_address)
                hsa_pkg::OFS_CTRL:
                begin
                    en_nxt = i_avs_writedata[hsa_pkg::CTRL_EN_BIT];
                    raw_nxt = i_avs_writedata[hsa_pkg::CTRL_RAW_BIT];
                    bayer_nxt = i_avs_writedata[hsa_pkg::CTRL_BAYER_BIT];
                    if (i_avs_writedata[hsa_pkg::CTRL_LS_LSB +: 3] <= hsa_pkg::LS_CUSTOM)
                    begin
                        ls_nxt = hsa_pkg::hsa_light_t'(i_avs_writedata[hsa_pkg::CTRL_LS_LSB +: 3]);
                        load = (ls_nxt != ls_r);
                        load_src = ls_nxt;
                    end
                end
                hsa_pkg::OFS_SEL:
                begin
                    // Codes above magenta are ignored
                    if (i_avs_writedata[2:0] <= hsa_pkg::COL_MAGENTA)
                    begin
                        sel_nxt = hsa_pkg::hsa_colour_t'(i_avs_writedata[2:0]);
                    end
                end
                // Stored as raw integers: hue Q3.5, saturation Q1.7
                hsa_pkg::OFS_HUE: hue_nxt[sel_r] = i_avs_writedata[7:0];
                hsa_pkg::OFS_SAT: sat_nxt[sel_r] = i_avs_writedata[7:0];
                hsa_pkg::OFS_CMD: load = i_avs_writedata[hsa_pkg::CMD_RESET_BIT];
                default: load = 1'b0;
            endcase
        end
        if (load)
        begin
            for (int k = 0; k < hsa_pkg::NUM_COLOURS; k++)
            begin
                hue_nxt[k] = hsa_pkg::LS_HUE_DEF[load_src][k];
                sat_nxt[k] = hsa_pkg::LS_SAT_DEF[load_src][k];
            end
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
        begin
            wait_r <= 1'b1;
            rdata_r <= 32'h0000_0000;
            en_r <= 1'b0;
            raw_r <= 1'b0;
            bayer_r <= 1'b0;
            ls_r <= hsa_pkg::LS_OFF;
            sel_r <= hsa_pkg::COL_RED;
            act_r <= 1'b0;
            byp_r <= 1'b0;
            for (int k = 0; k < hsa_pkg::NUM_COLOURS; k++)
            begin
                hue_r[k] <= hsa_pkg::HUE_NEUTRAL;
                sat_r[k] <= hsa_pkg::SAT_UNITY;
            end
        end
        else
        begin
            wait_r <= wait_nxt;
            rdata_r <= rdata_nxt;
            en_r <= en_nxt;
            raw_r <= raw_nxt;
            bayer_r <= bayer_nxt;
            ls_r <= ls_nxt;
            sel_r <= sel_nxt;
            act_r <= act_nxt;
            byp_r <= byp_nxt;
            hue_r <= hue_nxt;
            sat_r <= sat_nxt;
        end
    end

    assign o_avs_waitrequest = wait_r;
    assign o_avs_readdata = rdata_r;
    assign o_adjust_active = act_r;
    assign o_matrix_bypass = byp_r;

    // Pixel pipeline: decompose, adjust corners, recombine
    logic s1_v_r;
    logic s1_v_nxt;
    logic s1_act_r;
    logic s1_act_nxt;
    logic [3*PIX_W-1:0] s1_raw_r;
    logic [3*PIX_W-1:0] s1_raw_nxt;
    logic [PIX_W-1:0] s1_min_r;
    logic [PIX_W-1:0] s1_min_nxt;
    logic [PIX_W-1:0] s1_p_r;
    logic [PIX_W-1:0] s1_p_nxt;
    logic [PIX_W-1:0] s1_s_r;
    logic [PIX_W-1:0] s1_s_nxt;
    logic [2:0] s1_pi_r;
    logic [2:0] s1_pi_nxt;
    logic [2:0] s1_si_r;
    logic [2:0] s1_si_nxt;
    logic s2_v_r;
    logic s2_act_r;
    logic [3*PIX_W-1:0] s2_raw_r;
    logic [PIX_W-1:0] s2_min_r;
    logic [2:0] s2_pi_r;
    logic [2:0] s2_pt_r;
    logic [2:0] s2_si_r;
    logic [2:0] s2_st_r;
    logic [PIX_W:0] s2_pk_r;
    logic [PIX_W:0] s2_pm_r;
    logic [PIX_W:0] s2_sk_r;
    logic [PIX_W:0] s2_sm_r;
    logic [PIX_W:0] pk_c;
    logic [PIX_W:0] pm_c;
    logic [PIX_W:0] sk_c;
    logic [PIX_W:0] sm_c;
    logic [2:0] pt_c;
    logic [2:0] st_c;
    logic [SUM_W-1:0] corner_amt [hsa_pkg::NUM_COLOURS];
    logic [3*PIX_W-1:0] out_nxt;
    logic [3*PIX_W-1:0] out_r;
    logic out_v_r;

    function automatic logic [PIX_W-1:0] clip(input logic [SUM_W-1:0] v);
        clip = (|v[SUM_W-1:PIX_W]) ? {PIX_W{1'b1}} : v[PIX_W-1:0];
    endfunction : clip

    // Pixel = gray + primary corner amount + secondary corner amount
    always_comb
    begin
        s1_v_nxt = i_pix_valid;
        s1_act_nxt = act_c;
        s1_raw_nxt = {i_pix_r, i_pix_g, i_pix_b};
        if (i_pix_r >= i_pix_g && i_pix_r >= i_pix_b)
        begin
            s1_pi_nxt = hsa_pkg::COL_RED;
            s1_si_nxt = (i_pix_g >= i_pix_b) ? hsa_pkg::COL_YELLOW : hsa_pkg::COL_MAGENTA;
            s1_min_nxt = (i_pix_g >= i_pix_b) ? i_pix_b : i_pix_g;
            s1_p_nxt = i_pix_r - ((i_pix_g >= i_pix_b) ? i_pix_g : i_pix_b);
            s1_s_nxt = (i_pix_g >= i_pix_b) ? i_pix_g - i_pix_b : i_pix_b - i_pix_g;
        end
        else if (i_pix_g >= i_pix_b)
        begin
            s1_pi_nxt = hsa_pkg::COL_GREEN;
            s1_si_nxt = (i_pix_r >= i_pix_b) ? hsa_pkg::COL_YELLOW : hsa_pkg::COL_CYAN;
            s1_min_nxt = (i_pix_r >= i_pix_b) ? i_pix_b : i_pix_r;
            s1_p_nxt = i_pix_g - ((i_pix_r >= i_pix_b) ? i_pix_r : i_pix_b);
            s1_s_nxt = (i_pix_r >= i_pix_b) ? i_pix_r - i_pix_b : i_pix_b - i_pix_r;
        end
        else
        begin
            s1_pi_nxt = hsa_pkg::COL_BLUE;
            s1_si_nxt = (i_pix_r >= i_pix_g) ? hsa_pkg::COL_MAGENTA : hsa_pkg::COL_CYAN;
            s1_min_nxt = (i_pix_r >= i_pix_g) ? i_pix_g : i_pix_r;
            s1_p_nxt = i_pix_b - ((i_pix_r >= i_pix_g) ? i_pix_r : i_pix_g);
            s1_s_nxt = (i_pix_r >= i_pix_g) ? i_pix_r - i_pix_g : i_pix_g - i_pix_r;
        end
    end

    hsa_corner_adjust #(
        .PIX_W(PIX_W)
    ) u_primary (
        .i_amount(s1_p_r),
        .i_index(s1_pi_r),
        .i_sat(sat_r[s1_pi_r]),
        .i_hue(hue_r[s1_pi_r]),
        .o_kept(pk_c),
        .o_moved(pm_c),
        .o_target(pt_c)
    );

    hsa_corner_adjust #(
        .PIX_W(PIX_W)
    ) u_secondary (
        .i_amount(s1_s_r),
        .i_index(s1_si_r),
        .i_sat(sat_r[s1_si_r]),
        .i_hue(hue_r[s1_si_r]),
        .o_kept(sk_c),
        .o_moved(sm_c),
        .o_target(st_c)
    );

    // Adjacent pixels between two corners feel both corners' settings
    generate
        for (genvar k = 0; k < hsa_pkg::NUM_COLOURS; k++)
        begin : g_corner
            assign corner_amt[k] = ((s2_pi_r == 3'(k)) ? SUM_W'(s2_pk_r) : '0)
                + ((s2_pt_r == 3'(k)) ? SUM_W'(s2_pm_r) : '0)
                + ((s2_si_r == 3'(k)) ? SUM_W'(s2_sk_r) : '0)
                + ((s2_st_r == 3'(k)) ? SUM_W'(s2_sm_r) : '0);
        end
    endgenerate

    // Bypass keeps the raw pixel on the same three-stage path
    always_comb
    begin
        if (s2_act_r)
        begin
            out_nxt = {
                clip(SUM_W'(s2_min_r) + corner_amt[0] + corner_amt[1] + corner_amt[5]),
                clip(SUM_W'(s2_min_r) + corner_amt[1] + corner_amt[2] + corner_amt[3]),
                clip(SUM_W'(s2_min_r) + corner_amt[3] + corner_amt[4] + corner_amt[5])
            };
        end
        else
        begin
            out_nxt = s2_raw_r;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
        begin
            s1_v_r <= 1'b0;
            s2_v_r <= 1'b0;
            out_v_r <= 1'b0;
            s1_act_r <= 1'b0;
            s2_act_r <= 1'b0;
            s1_raw_r <= '0;
            s2_raw_r <= '0;
            s1_min_r <= '0;
            s2_min_r <= '0;
            s1_p_r <= '0;
            s1_s_r <= '0;
            s1_pi_r <= 3'h0;
            s1_si_r <= 3'h0;
            s2_pi_r <= 3'h0;
            s2_si_r <= 3'h0;
            s2_pt_r <= 3'h0;
            s2_st_r <= 3'h0;
            s2_pk_r <= '0;
            s2_pm_r <= '0;
            s2_sk_r <= '0;
            s2_sm_r <= '0;
            out_r <= '0;
        end
        else
        begin
            s1_v_r <= s1_v_nxt;
            s1_act_r <= s1_act_nxt;
            s1_raw_r <= s1_raw_nxt;
            s1_min_r <= s1_min_nxt;
            s1_p_r <= s1_p_nxt;
            s1_s_r <= s1_s_nxt;
            s1_pi_r <= s1_pi_nxt;
            s1_si_r <= s1_si_nxt;
            s2_v_r <= s1_v_r;
            s2_act_r <= s1_act_r;
            s2_raw_r <= s1_raw_r;
            s2_min_r <= s1_min_r;
            s2_pi_r <= s1_pi_r;
            s2_si_r <= s1_si_r;
            s2_pt_r <= pt_c;
            s2_st_r <= st_c;
            s2_pk_r <= pk_c;
            s2_pm_r <= pm_c;
            s2_sk_r <= sk_c;
            s2_sm_r <= sm_c;
            out_v_r <= s2_v_r;
            out_r <= out_nxt;
        end
    end

    assign o_pix_valid = out_v_r;
    assign o_pix_r = out_r[3*PIX_W-1:2*PIX_W];
    assign o_pix_g = out_r[2*PIX_W-1:PIX_W];
    assign o_pix_b = out_r[PIX_W-1:0];

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rstn);

    sequence s_wr(logic [4:0] ofs);
        i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0] && i_avs_address == ofs;
    endsequence

    sequence s_idle_pixel;
        i_pix_valid && !act_c ##3 o_pix_valid;
    endsequence

    property p_bayer_bypass;
        (bayer_r && !raw_r) |=> o_matrix_bypass && !o_adjust_active;
    endproperty
    a_bayer_bypass: assert property (p_bayer_bypass) else $error("Bayer bypass not applied");

    property p_yuv_ignores_raw;
        !bayer_r |=> o_adjust_active == $past(en_r);
    endproperty
    a_yuv_ignores_raw: assert property (p_yuv_ignores_raw) else $error("Raw mode not ignored");

    property p_enable_off;
        !en_r |=> !o_adjust_active;
    endproperty
    a_enable_off: assert property (p_enable_off) else $error("Active while disabled");

    property p_latency;
        i_pix_valid |-> ##3 o_pix_valid;
    endproperty
    a_latency: assert property (p_latency) else $error("Pixel latency not three");

    property p_passthrough;
        s_idle_pixel |-> o_pix_r == $past(i_pix_r, 3) && o_pix_g == $past(i_pix_g, 3)
            && o_pix_b == $past(i_pix_b, 3);
    endproperty
    a_passthrough: assert property (p_passthrough) else $error("Bypassed pixel altered");

    property p_sel_hue;
        s_wr(hsa_pkg::OFS_HUE) |=> hue_r[$past(sel_r)] == $past(i_avs_writedata[7:0]);
    endproperty
    a_sel_hue: assert property (p_sel_hue) else $error("Hue not stored for selection");

    property p_sel_legal;
        s_wr(hsa_pkg::OFS_SEL) and (i_avs_writedata[2:0] > 3'h5) |=> $stable(sel_r);
    endproperty
    a_sel_legal: assert property (p_sel_legal) else $error("Illegal colour accepted");

    property p_reset_cmd;
        s_wr(hsa_pkg::OFS_CMD) and i_avs_writedata[0] |=> hue_r[0] == hsa_pkg::LS_HUE_DEF[ls_r][0]
            && sat_r[5] == hsa_pkg::LS_SAT_DEF[ls_r][5];
    endproperty
    a_reset_cmd: assert property (p_reset_cmd) else $error("Reset command did not reload");

    property p_custom;
        s_wr(hsa_pkg::OFS_CTRL) and (ls_r != hsa_pkg::LS_CUSTOM)
            and (i_avs_writedata[hsa_pkg::CTRL_LS_LSB +: 3] == hsa_pkg::LS_CUSTOM) |=> ls_r == hsa_pkg::LS_CUSTOM
            && hue_r[2] == hsa_pkg::HUE_NEUTRAL && sat_r[3] == hsa_pkg::SAT_UNITY;
    endproperty
    a_custom: assert property (p_custom) else $error("Custom source not neutral");

    property p_ack;
        req && o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest;
    endproperty
    a_ack: assert property (p_ack) else $error("Bus answer not one cycle");
endmodule : hsa_adjust

// *** hsa_adjust_tb.sv ***
`timescale 1ns/1ps
module hsa_adjust_tb;
    logic clk, rstn, rd, wr, go, sv, ov, mb, aa, wq;
    logic [4:0] adr;
    logic [31:0] wd, rdd, q, rv;
    logic [23:0] gp, sp;
    logic [7:0] o_r, o_g, o_b;
    logic [2:0] vsh, selm;
    logic [7:0] hm [6];
    logic [7:0] sm [6];
    logic [6:0] ctrl;
    logic [31:0] seed = 32'h3c49;
    logic [15:0] cor [4] = '{16'h80ff, 16'h7fff, 16'h0000, 16'hc040};
    logic [23:0] expq [$];
    int num_errors = 0;
    int n_tests = 0;

    hsa_pix_src hsa_pix_src_i (.i_clk(clk), .i_go(go), .i_pix(gp), .o_valid(sv), .o_pix(sp));
    hsa_adjust hsa_adjust_i (.i_sys_clk(clk), .i_rstn(rstn), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf), .o_avs_readdata(rdd),
        .o_avs_waitrequest(wq), .i_pix_valid(sv), .i_pix_r(sp[23:16]), .i_pix_g(sp[15:8]),
        .i_pix_b(sp[7:0]), .o_pix_valid(ov), .o_pix_r(o_r), .o_pix_g(o_g), .o_pix_b(o_b),
        .o_matrix_bypass(mb), .o_adjust_active(aa));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    function automatic logic [23:0] exp_pix(logic [23:0] p);
        int v[3];
        int acc[6];
        int o[3];
        int mx, mn, md, a, s, k, h, m;
        if (!(ctrl[0] && (!ctrl[2] || ctrl[1])))
            return p;
        v = '{p[23:16], p[15:8], p[7:0]};
        acc = '{default: 0};
        mx = (v[1] > v[0]) ? 1 : 0;
        mx = (v[2] > v[mx]) ? 2 : mx;
        mn = (mx + 1) % 3;
        mn = (v[(mx + 2) % 3] < v[mn]) ? (mx + 2) % 3 : mn;
        md = 3 - mx - mn;
        for (int i = 0; i < 2; i++)
        begin
            k = i ? ((mx + md == 2) ? 5 : mx + md) : 2 * mx;
            a = i ? v[md] - v[mn] : v[mx] - v[md];
            s = (a * sm[k]) >> 7;
            h = $signed(hm[k]);
            m = (s * (h < 0 ? -h : h)) >> 7;
            acc[k] += s - m;
            acc[(k + (h < 0 ? 1 : 5)) % 6] += m;
        end
        for (int c = 0; c < 3; c++)
        begin
            o[c] = v[mn] + acc[2 * c] + acc[(2 * c + 1) % 6] + acc[(2 * c + 5) % 6];
            o[c] = (o[c] > 255) ? 255 : o[c];
        end
        return {o[0][7:0], o[1][7:0], o[2][7:0]};
    endfunction : exp_pix

    task automatic check(string nm, logic [31:0] got, logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= d;
        do
            @(posedge clk);
        while (wq !== 1'b0);
        q = rdd;
        wr <= 0;
        rd <= 0;
    endtask : bus

    task automatic rchk(string nm, logic [4:0] a, logic [31:0] e);
        bus(0, a, 0);
        check(nm, q, e);
    endtask : rchk

    task automatic load(int ls);
        for (int c = 0; c < 6; c++)
        begin
            hm[c] = hsa_pkg::LS_HUE_DEF[ls][c];
            sm[c] = hsa_pkg::LS_SAT_DEF[ls][c];
        end
    endtask : load

    task automatic setc(logic [6:0] v);
        bus(1, hsa_pkg::OFS_CTRL, {25'h0, v});
        if (v[6:4] <= 4 && v[6:4] != ctrl[6:4])
            load(v[6:4]);
        ctrl = (v[6:4] > 4) ? {ctrl[6:4], v[3:0]} : v;
    endtask : setc

    task automatic setcol(logic [2:0] c, logic [7:0] h, logic [7:0] s);
        bus(1, hsa_pkg::OFS_SEL, c);
        hm[c] = h;
        sm[c] = s;
        bus(1, hsa_pkg::OFS_HUE, h);
        bus(1, hsa_pkg::OFS_SAT, s);
    endtask : setcol

    task automatic burst(int n);
        logic [31:0] p;
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk);
            p = xs();
            go <= 1;
            gp <= p[23:0];
            expq.push_back(exp_pix(p[23:0]));
        end
        @(posedge clk);
        go <= 0;
        repeat (8) @(posedge clk);
        check("drained", expq.size(), 0);
    endtask : burst

    always @(posedge clk)
    begin
        vsh <= {vsh[1:0], sv};
        if (rstn)
            check("valid", ov, vsh[2]);
        if (ov === 1'b1 && expq.size() > 0)
            check("pixel", {o_r, o_g, o_b}, expq.pop_front());
    end

    initial
    begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end

    initial
    begin
        repeat (60000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end

    initial
    begin
        rstn = 0;
        rd = 0;
        wr = 0;
        adr = 0;
        wd = 0;
        go = 0;
        gp = 0;
        vsh = 0;
        ctrl = 0;
        selm = 0;
        load(0);
        repeat (10) @(posedge clk);
        rstn <= 1;
        rchk("ctrl", hsa_pkg::OFS_CTRL, 0);
        for (int c = 0; c < 6; c++)
        begin
            bus(1, hsa_pkg::OFS_SEL, c);
            rchk("hue", hsa_pkg::OFS_HUE, 0);
            rchk("sat", hsa_pkg::OFS_SAT, 32'h80);
        end
        rchk("cmd", hsa_pkg::OFS_CMD, 0);
        rchk("unmapped", 5'h18, 0);
        $display("test reset done");
        for (int c = 0; c < 7; c++)
        begin
            rv = xs();
            selm = (c < 6) ? c[2:0] : selm;
            setcol(c[2:0], rv[7:0], rv[15:8]);
            hm[selm] = rv[7:0];
            sm[selm] = rv[15:8];
            rchk("sel", hsa_pkg::OFS_SEL, selm);
            rchk("hue rb", hsa_pkg::OFS_HUE, hm[selm]);
            rchk("sat rb", hsa_pkg::OFS_SAT, sm[selm]);
            burst(16);
        end
        $display("test colours done");
        setc(7'h01);
        foreach (cor[i])
        begin
            setcol(3'h0, cor[i][15:8], cor[i][7:0]);
            burst(24);
        end
        $display("test corners done");
        for (int m = 0; m < 8; m++)
        begin
            setc({4'h0, m[2:0]});
            rchk("stat", hsa_pkg::OFS_STAT, {m[2] & !m[1], m[0] & (!m[2] | m[1])});
            check("bypass", mb, m[2] & !m[1]);
            check("active", aa, m[0] & (!m[2] | m[1]));
            burst(16);
        end
        $display("test modes done");
        for (int ls = 1; ls < 6; ls++)
        begin
            setc({ls[2:0], 4'h1});
            burst(16);
            for (int c = 0; c < 6; c++)
            begin
                bus(1, hsa_pkg::OFS_SEL, c);
                rchk("ls hue", hsa_pkg::OFS_HUE, hm[c]);
                rchk("ls sat", hsa_pkg::OFS_SAT, sm[c]);
            end
        end
        setcol(3'h5, 8'h5a, 8'h21);
        bus(1, hsa_pkg::OFS_CMD, 1);
        load(ctrl[6:4]);
        rchk("reset hue", hsa_pkg::OFS_HUE, hm[5]);
        rchk("reset sat", hsa_pkg::OFS_SAT, sm[5]);
        $display("test light done");
        report_and_stop();
    end
endmodule : hsa_adjust_tb

// *** hsa_corner_adjust.sv ***
`timescale 1ns/1ps
module hsa_corner_adjust #(
    parameter int PIX_W = 8
) (
    input wire logic [PIX_W-1:0] i_amount,
    input wire logic [2:0] i_index,
    input wire logic [hsa_pkg::SET_W-1:0] i_sat,
    input wire logic [hsa_pkg::SET_W-1:0] i_hue,
    output logic [PIX_W:0] o_kept,
    output logic [PIX_W:0] o_moved,
    output logic [2:0] o_target
);
    logic [PIX_W+7:0] scaled_full;
    logic [PIX_W:0] scaled;
    logic [7:0] hue_mag;
    logic [PIX_W+8:0] moved_full;

    // Saturation scales the corner amount; 128 is unity, 0 leaves gray
    assign scaled_full = i_amount * i_sat;
    assign scaled = scaled_full[PIX_W+hsa_pkg::SAT_FRAC_BITS:hsa_pkg::SAT_FRAC_BITS];
    // Magnitude 128 moves the whole amount onto the neighbour
    assign hue_mag = i_hue[7] ? 8'(~i_hue + 8'h01) : i_hue;
    assign moved_full = scaled * hue_mag;
    assign o_moved = moved_full[PIX_W+7:7];
    assign o_kept = scaled - o_moved;

    // Negative goes to the next corner, positive to the previous one
    always_comb
    begin
        if (i_hue[7])
        begin
            o_target = (i_index == 3'(hsa_pkg::NUM_COLOURS - 1)) ? 3'h0 : 3'(i_index + 3'h1);
        end
        else
        begin
            o_target = (i_index == 3'h0) ? 3'(hsa_pkg::NUM_COLOURS - 1) : 3'(i_index - 3'h1);
        end
    end
endmodule : hsa_corner_adjust

// *** hsa_pix_src.sv ***
`timescale 1ns/1ps
module hsa_pix_src (
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [23:0] i_pix,
    output logic o_valid,
    output logic [23:0] o_pix
);
    initial
    begin
        o_valid = 0;
        o_pix = 0;
    end
    // Idle cycles invert the previous output, so every second idle cycle repeats the last pixel
    always @(posedge i_clk)
    begin
        o_valid <= i_go;
        o_pix <= i_go ? i_pix : ~o_pix;
    end
endmodule : hsa_pix_src

// *** hsa_pkg.sv ***
// Notes on behaviour
// - Bayer format without processed-raw: colour matrix and this adjustment are bypassed.
// - Non-Bayer formats ignore the processed-raw setting.
// - One enable bit switches the whole adjustment on or off.
// - A selector picks red, yellow, green, cyan, blue or magenta.
// - Hue and saturation accesses go to the selected colour; six pairs are kept.
// - Hue in real form spans -4.0 to +3.96875.
// - Integer hue spans -128 to +127; 32 steps equal one unit.
// - Saturation in real form spans 0.0 to +1.99219.
// - Integer saturation spans 0 to 255; 128 is unity, 0 is none.
// - Each pixel takes the settings of its predominant colour and of the secondary colour between its two largest components.
// - Adjusting a colour partly affects both hexagon neighbours.
// - Hue rotates a corner toward a neighbour, fully reaching it only at -128.
// - Negative hue turns red toward yellow, positive toward magenta.
// - Minimum saturation turns the colour gray; more saturation adds colourfulness.
// - Reset command reloads all settings for the current light source.
// - Changing light source loads its settings; custom loads neutral values.
package hsa_pkg;
    localparam int AVS_ADDR_W = 5;
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_SEL = 5'h04;
    localparam logic [4:0] OFS_HUE = 5'h08;
    localparam logic [4:0] OFS_SAT = 5'h0c;
    localparam logic [4:0] OFS_CMD = 5'h10;
    localparam logic [4:0] OFS_STAT = 5'h14;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_RAW_BIT = 1;
    localparam int CTRL_BAYER_BIT = 2;
    localparam int CTRL_LS_LSB = 4;
    localparam int CMD_RESET_BIT = 0;
    localparam int STAT_ACT_BIT = 0;
    localparam int STAT_BYP_BIT = 1;
    localparam int SET_W = 8;
    localparam int NUM_COLOURS = 6;
    localparam int NUM_LIGHTS = 5;
    localparam int HUE_FRAC_BITS = 5;
    localparam int SAT_FRAC_BITS = 7;
    localparam logic [7:0] HUE_NEUTRAL = 8'h00;
    localparam logic [7:0] SAT_UNITY = 8'h80;
    localparam int PIPE_LAT = 3;

    typedef enum logic [2:0] {
        COL_RED = 3'h0,
        COL_YELLOW = 3'h1,
        COL_GREEN = 3'h2,
        COL_CYAN = 3'h3,
        COL_BLUE = 3'h4,
        COL_MAGENTA = 3'h5
    } hsa_colour_t;

    typedef enum logic [2:0] {
        LS_OFF = 3'h0,
        LS_TUNGSTEN = 3'h1,
        LS_DAYLIGHT = 3'h2,
        LS_D6500 = 3'h3,
        LS_CUSTOM = 3'h4
    } hsa_light_t;

    // Per light source, per colour red..magenta
    localparam logic [7:0] LS_HUE_DEF [NUM_LIGHTS][NUM_COLOURS] = '{
        '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00},
        '{8'hfc, 8'h00, 8'h02, 8'h00, 8'h04, 8'h00},
        '{8'hfe, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00},
        '{8'hff, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00},
        '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}
    };
    localparam logic [7:0] LS_SAT_DEF [NUM_LIGHTS][NUM_COLOURS] = '{
        '{8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80},
        '{8'h78, 8'h80, 8'h88, 8'h88, 8'h90, 8'h80},
        '{8'h88, 8'h80, 8'h84, 8'h80, 8'h88, 8'h80},
        '{8'h8c, 8'h84, 8'h88, 8'h84, 8'h8c, 8'h84},
        '{8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80}
    };
endpackage : hsa_pkg
